// >>> rtl/cbag_defines.vh
// constants for the circular / bit-reverse address generator and bus exchange
// assumes a single processor clock; no software-visible registers on a bus
//
// Contract
// RULE_01: circular next index is modulo-wrapped offset plus base
// RULE_02: index and length unsigned, modify signed
// RULE_03: program keeps modify magnitude below buffer length
// RULE_04: buffer base aligned to covering power of two
// RULE_05: modify is 14-bit two's complement
// RULE_06: wrap keeps correct offset without direct hit
// RULE_07: only first generator may reverse addresses
// RULE_08: reversal mirrors 14-bit address about bits 6/7
// RULE_09: mode bit enables reversal until cleared
// RULE_10: written-back index stays in normal order
// RULE_11: program sets modify to 2^(14-N) for N bits
// RULE_12: exchange moves upper 16 program bits, extension 8
// RULE_13: extension register writable and readable by moves
// RULE_14: dual read routes program upper bits to Y path
// RULE_15: zero length gives linear, nonzero gives circular
// RULE_16: access uses old index, then index plus modify
// RULE_17: 14-bit regs; read zero-pad index/length, sign-extend modify
// RULE_18: index pairs only with own generator's modify registers
// RULE_19: base is index with low n bits cleared
// RULE_20: linear results wrap modulo 14 bits silently
`ifndef CBAG_DEFINES_VH
`define CBAG_DEFINES_VH
`define CBAG_AW 14
`define CBAG_DW 16
`define CBAG_PW 24
`define CBAG_XW 8
`define CBAG_REG_IDX 2'h0
`define CBAG_REG_MOD 2'h1
`define CBAG_REG_LEN 2'h2
`define CBAG_XREG_RST 8'h00
`define CBAG_BITREV_RST 1'b0
`endif

// >>> rtl/cbag_top.v
// two data address generators with modulo logic, bit-reverse on the first only, plus program/data bus exchange
// assumes the sequencer presents one access per generator per cycle; register moves are strobes
`timescale 1ns/1ps
`include "cbag_defines.vh"

module cbag_gen #(
    parameter AW = 14,
    parameter REV_OK = 0
) (
    input wire clk,
    input wire arst_n,
    input wire acc_en,
    input wire [1:0] acc_idx_sel,
    input wire [1:0] acc_mod_sel,
    input wire rev_en,
    output reg [AW-1:0] addr_q,
    output reg addr_vld_q,
    input wire wr_en,
    input wire [1:0] wr_kind,
    input wire [1:0] wr_sel,
    input wire [15:0] wr_data,
    input wire [1:0] rd_kind,
    input wire [1:0] rd_sel,
    output reg [15:0] rd_data
);
    // no reset values for the register files; contents are random after reset
    reg [AW-1:0] idx_q [0:3];
    reg [AW-1:0] mod_q [0:3];
    reg [AW-1:0] len_q [0:3];
    reg [AW-1:0] cur_i;
    reg [AW-1:0] cur_m;
    reg [AW-1:0] cur_l;
    reg [AW-1:0] lin;
    reg [AW-1:0] mask;
    reg [AW-1:0] base;
    reg [AW:0] off;
    reg [AW:0] wrapped;
    reg [AW-1:0] next_i;
    reg [AW-1:0] rev;
    integer k;

    always @* begin
        cur_i = idx_q[acc_idx_sel];
        cur_m = mod_q[acc_mod_sel]; // RULE_18
        cur_l = len_q[acc_idx_sel];
        lin = cur_i + cur_m; // RULE_20 RULE_05
        // mask covers the smallest power of two not below the length
        mask = cur_l - {{(AW-1){1'b0}}, 1'b1};
        for (k = 1; k < AW; k = k + 1) begin
            mask = mask | (mask >> k);
        end
        base = cur_i & ~mask; // RULE_19 RULE_04
        // offset is signed: unsigned index and length, signed modify
        off = {1'b0, cur_i - base} + {cur_m[AW-1], cur_m}; // RULE_02
        if (off[AW]) begin
            wrapped = off + {1'b0, cur_l}; // RULE_06
        end else if (off >= {1'b0, cur_l}) begin
            wrapped = off - {1'b0, cur_l}; // RULE_06
        end else begin
            wrapped = off;
        end
        if (cur_l == {AW{1'b0}}) begin
            next_i = lin; // RULE_15
        end else begin
            next_i = wrapped[AW-1:0] + base; // RULE_01
        end
        for (k = 0; k < AW; k = k + 1) begin
            rev[k] = cur_i[AW-1-k]; // RULE_08
        end
    end

    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            addr_q <= {AW{1'b0}};
            addr_vld_q <= 1'b0;
        end else begin
            addr_vld_q <= acc_en;
            if (acc_en) begin
                addr_q <= (REV_OK != 0 && rev_en) ? rev : cur_i; // RULE_16 RULE_07 RULE_09
            end
        end
    end

    always @(posedge clk) begin
        if (wr_en && wr_kind == `CBAG_REG_MOD) begin
            mod_q[wr_sel] <= wr_data[AW-1:0]; // RULE_17
        end
        if (wr_en && wr_kind == `CBAG_REG_LEN) begin
            len_q[wr_sel] <= wr_data[AW-1:0];
        end
        if (wr_en && wr_kind == `CBAG_REG_IDX) begin
            idx_q[wr_sel] <= wr_data[AW-1:0];
        end else if (acc_en) begin
            idx_q[acc_idx_sel] <= next_i; // RULE_16 RULE_10
        end
    end

    always @* begin
        case (rd_kind)
            `CBAG_REG_IDX: rd_data = {{(16-AW){1'b0}}, idx_q[rd_sel]}; // RULE_17
            `CBAG_REG_MOD: rd_data = {{(16-AW){mod_q[rd_sel][AW-1]}}, mod_q[rd_sel]}; // RULE_17
            `CBAG_REG_LEN: rd_data = {{(16-AW){1'b0}}, len_q[rd_sel]};
            default: rd_data = 16'h0000;
        endcase
    end
endmodule

module cbag_top #(
    parameter AW = 14
) (
    // clock and reset
    input wire clk,
    input wire arst_n,
    // mode status register bit for reversal
    input wire bitrev_mode,
    // first generator access
    input wire g1_acc_en,
    input wire [1:0] g1_idx_sel,
    input wire [1:0] g1_mod_sel,
    output wire [AW-1:0] g1_addr,
    output wire g1_addr_vld,
    // second generator access
    input wire g2_acc_en,
    input wire [1:0] g2_idx_sel,
    input wire [1:0] g2_mod_sel,
    output wire [AW-1:0] g2_addr,
    output wire g2_addr_vld,
    // generator register moves over the data bus
    input wire dag_wr_en,
    input wire dag_wr_gen,
    input wire [1:0] dag_wr_kind,
    input wire [1:0] dag_wr_sel,
    input wire [15:0] dag_wr_data,
    input wire dag_rd_gen,
    input wire [1:0] dag_rd_kind,
    input wire [1:0] dag_rd_sel,
    output wire [15:0] dag_rd_data,
    // program/data bus exchange
    input wire [23:0] pgm_bus_rd_data,
    input wire pm_data_rd,
    input wire dual_rd,
    input wire [15:0] data_bus_wr_data,
    input wire ext_wr_en,
    output reg [15:0] data_bus_from_pgm_q,
    output wire [15:0] ext_rd_data,
    output wire [23:0] pgm_bus_wr_data,
    output reg [15:0] y_operand_q,
    output reg y_operand_vld_q
);
    reg [7:0] ext_q;
    wire [15:0] g1_rd;
    wire [15:0] g2_rd;
    // mode bit resampled into a register every cycle; reversal follows it one cycle later
    reg bitrev_q;

    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            bitrev_q <= `CBAG_BITREV_RST;
        end else begin
            bitrev_q <= bitrev_mode; // RULE_09
        end
    end

    cbag_gen #(.AW(AW), .REV_OK(1)) u_first (
        .clk(clk),
        .arst_n(arst_n),
        .acc_en(g1_acc_en),
        .acc_idx_sel(g1_idx_sel),
        .acc_mod_sel(g1_mod_sel),
        .rev_en(bitrev_q),
        .addr_q(g1_addr),
        .addr_vld_q(g1_addr_vld),
        .wr_en(dag_wr_en && !dag_wr_gen),
        .wr_kind(dag_wr_kind),
        .wr_sel(dag_wr_sel),
        .wr_data(dag_wr_data),
        .rd_kind(dag_rd_kind),
        .rd_sel(dag_rd_sel),
        .rd_data(g1_rd)
    );

    cbag_gen #(.AW(AW), .REV_OK(0)) u_second (
        .clk(clk),
        .arst_n(arst_n),
        .acc_en(g2_acc_en),
        .acc_idx_sel(g2_idx_sel),
        .acc_mod_sel(g2_mod_sel),
        .rev_en(1'b0),
        .addr_q(g2_addr),
        .addr_vld_q(g2_addr_vld),
        .wr_en(dag_wr_en && dag_wr_gen),
        .wr_kind(dag_wr_kind),
        .wr_sel(dag_wr_sel),
        .wr_data(dag_wr_data),
        .rd_kind(dag_rd_kind),
        .rd_sel(dag_rd_sel),
        .rd_data(g2_rd)
    ); // RULE_07

    assign dag_rd_data = dag_rd_gen ? g2_rd : g1_rd;

    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            ext_q <= `CBAG_XREG_RST;
            data_bus_from_pgm_q <= 16'h0000;
            y_operand_q <= 16'h0000;
            y_operand_vld_q <= 1'b0;
        end else begin
            y_operand_vld_q <= pm_data_rd && dual_rd;
            if (ext_wr_en) begin
                ext_q <= data_bus_wr_data[7:0]; // RULE_13
            end else if (pm_data_rd) begin
                ext_q <= pgm_bus_rd_data[7:0]; // RULE_12
            end
            if (pm_data_rd && dual_rd) begin
                y_operand_q <= pgm_bus_rd_data[23:8]; // RULE_14
            end else if (pm_data_rd) begin
                data_bus_from_pgm_q <= pgm_bus_rd_data[23:8]; // RULE_12
            end
        end
    end

    assign ext_rd_data = {8'h00, ext_q}; // RULE_13
    assign pgm_bus_wr_data = {data_bus_wr_data, ext_q}; // RULE_12
endmodule

// >>> tb/cbag_asserts.sv
// port checker for the address generator top
// assumes one clock clk and asynchronous active-low arst_n
`timescale 1ns/1ps
module cbag_asserts #(
    parameter AW = 14
) (
    input wire clk, input wire arst_n,
    input wire g1_acc_en, input wire g1_addr_vld,
    input wire g2_acc_en, input wire [AW-1:0] g2_addr, input wire g2_addr_vld,
    input wire pm_data_rd, input wire dual_rd, input wire [23:0] pgm_bus_rd_data,
    input wire [15:0] data_bus_wr_data, input wire ext_wr_en, input wire [15:0] data_bus_from_pgm_q,
    input wire [15:0] ext_rd_data, input wire [23:0] pgm_bus_wr_data,
    input wire [15:0] y_operand_q, input wire y_operand_vld_q
);
    default clocking @(posedge clk); endclocking
    default disable iff (!arst_n);
    sequence s_dual; pm_data_rd && dual_rd; endsequence
    sequence s_single; pm_data_rd && !dual_rd; endsequence
    property p_g1_vld; g1_acc_en |=> g1_addr_vld; endproperty
    property p_g1_quiet; !g1_acc_en |=> !g1_addr_vld; endproperty
    property p_g2_hold; !g2_acc_en |=> !g2_addr_vld && $stable(g2_addr); endproperty
    property p_ext_high; ext_rd_data[15:8] == 8'h00; endproperty
    property p_pm_wr; pgm_bus_wr_data == {data_bus_wr_data, ext_rd_data[7:0]}; endproperty
    property p_ext_load; ext_wr_en |=> ext_rd_data[7:0] == $past(data_bus_wr_data[7:0]); endproperty
    property p_y_path; s_dual |=> y_operand_vld_q && y_operand_q == $past(pgm_bus_rd_data[23:8]); endproperty
    property p_exch; s_single |=> !y_operand_vld_q && data_bus_from_pgm_q == $past(pgm_bus_rd_data[23:8]); endproperty
    a_g1_vld: assert property (p_g1_vld) else $error("g1 valid missing");
    a_g1_quiet: assert property (p_g1_quiet) else $error("g1 valid without access");
    a_g2_hold: assert property (p_g2_hold) else $error("g2 address moved idle");
    a_ext_high: assert property (p_ext_high) else $error("extension read upper not zero");
    a_pm_wr: assert property (p_pm_wr) else $error("pm write word wrong");
    a_ext_load: assert property (p_ext_load) else $error("extension load wrong");
    a_y_path: assert property (p_y_path) else $error("y operand path wrong");
    a_exch: assert property (p_exch) else $error("exchange read wrong");
endmodule
bind cbag_top cbag_asserts #(.AW(AW)) u_cbag_asserts (.*);

// >>> tb/cbag_pm_model.sv
// program memory model: word built from the second generator's address
// assumes one-cycle read pulses; a released bus shows the inverse of the last word
`timescale 1ns/1ps
module cbag_pm_model (
    input wire clk,
    input wire [13:0] addr,
    input wire rd,
    output logic [23:0] data
);
    logic [23:0] last_q = 24'h000000;
    always @(posedge clk) if (rd) last_q <= data;
    assign data = rd ? {2'h0, addr, 8'h5A} : ~last_q;
endmodule

// >>> tb/circular_bitrev_address_gen_bench.sv
// self-checking bench for the address generator top
// assumes the program memory model answers reads from the second generator's address
`timescale 1ns/1ps
module circular_bitrev_address_gen_bench;
    logic clk = 0, arst_n = 0, bitrev_mode = 0, g1_acc_en = 0, g2_acc_en = 0, dag_wr_en = 0;
    logic dag_wr_gen = 0, dag_rd_gen = 0, pm_data_rd = 0, dual_rd = 0, ext_wr_en = 0;
    logic [1:0] g1_idx_sel = 0, g1_mod_sel = 0, g2_idx_sel = 0, g2_mod_sel = 0;
    logic [1:0] dag_wr_kind = 0, dag_wr_sel = 0, dag_rd_kind = 0, dag_rd_sel = 0;
    logic [15:0] dag_wr_data = 0, data_bus_wr_data = 0;
    wire [13:0] g1_addr, g2_addr;
    wire g1_addr_vld, g2_addr_vld, y_operand_vld_q;
    wire [15:0] dag_rd_data, data_bus_from_pgm_q, ext_rd_data, y_operand_q;
    wire [23:0] pgm_bus_rd_data, pgm_bus_wr_data;
    int n_errors = 0, n_compared = 0;
    always #2.5 clk = ~clk;
    cbag_top u_cbag_top (.*);
    cbag_pm_model u_cbag_pm_model (.clk(clk), .addr(g2_addr), .rd(pm_data_rd), .data(pgm_bus_rd_data));
    task automatic chk(input string what, input logic [23:0] e, input logic [23:0] got);
        n_compared++;
        if (got !== e) begin
            n_errors++;
            $display("BAD %s expected %h seen %h", what, e, got);
        end
    endtask
    task automatic wr(input logic g, input logic [1:0] k, input logic [1:0] s, input logic [15:0] d);
        @(posedge clk); #1;
        {dag_wr_en, dag_wr_gen, dag_wr_kind, dag_wr_sel, dag_wr_data} = {1'h1, g, k, s, d};
        @(posedge clk); #1;
        dag_wr_en = 1'h0;
    endtask
    task automatic ld(input logic g, input logic [1:0] s, input logic [15:0] i, m, l);
        wr(g, 2'h0, s, i);
        wr(g, 2'h1, s, m);
        wr(g, 2'h2, s, l);
    endtask
    task automatic rd(input logic g, input logic [1:0] k, input logic [1:0] s, input logic [15:0] e);
        @(posedge clk); #1;
        {dag_rd_gen, dag_rd_kind, dag_rd_sel} = {g, k, s};
        #1;
        chk("reg read", {8'h00, e}, {8'h00, dag_rd_data});
    endtask
    // q holds n expected addresses, the first in the highest used slot
    task automatic walk(input logic g, input logic [1:0] s, input logic [1:0] m, input logic [83:0] q, input int n);
        for (int i = 0; i < n; i++) begin
            @(posedge clk); #1;
            if (g) {g2_acc_en, g2_idx_sel, g2_mod_sel} = {1'h1, s, m};
            else {g1_acc_en, g1_idx_sel, g1_mod_sel} = {1'h1, s, m};
            @(posedge clk); #1;
            {g1_acc_en, g2_acc_en} = 2'h0;
            chk("address", {10'h000, q[(n - 1 - i) * 14 +: 14]}, {10'h000, g ? g2_addr : g1_addr});
        end
    endtask
    task automatic pm(input logic d);
        @(posedge clk); #1;
        {pm_data_rd, dual_rd} = {1'h1, d};
        @(posedge clk); #1;
        pm_data_rd = 1'h0;
        chk("pm upper", 24'h000123, {8'h00, d ? y_operand_q : data_bus_from_pgm_q});
        chk("ext from pm", 24'h00005A, {8'h00, ext_rd_data});
    endtask
    task automatic t_circ;
        ld(0, 2'h0, 16'h5, 16'h1, 16'h3);
        walk(0, 2'h0, 2'h0, 84'({14'h5, 14'h6, 14'h4, 14'h5}), 4);
        ld(0, 2'h0, 16'h5, 16'h3FFF, 16'h3);
        walk(0, 2'h0, 2'h0, 84'({14'h5, 14'h4, 14'h6, 14'h5}), 4);
        rd(0, 2'h1, 2'h0, 16'hFFFF);
        ld(0, 2'h1, 16'h9, 16'h3, 16'h5);
        walk(0, 2'h1, 2'h1, 84'({14'h9, 14'hC, 14'hA, 14'h8, 14'hB, 14'h9}), 6);
        rd(0, 2'h2, 2'h1, 16'h5);
        ld(0, 2'h3, 16'h3FFE, 16'h3, 16'h0);
        walk(0, 2'h3, 2'h3, 84'({14'h3FFE, 14'h1}), 2);
        rd(0, 2'h0, 2'h3, 16'h4);
        walk(0, 2'h3, 2'h0, 84'({14'h4, 14'h3}), 2);
    endtask
    task automatic t_rev;
        @(posedge clk); #1;
        bitrev_mode = 1'h1;
        ld(0, 2'h2, 16'h1, 16'h1, 16'h0);
        walk(0, 2'h2, 2'h2, 84'({14'h2000, 14'h1000}), 2);
        rd(0, 2'h0, 2'h2, 16'h3);
        ld(0, 2'h1, 16'h0, 16'h1000, 16'h0);
        walk(0, 2'h1, 2'h1, 84'({14'h0, 14'h2, 14'h1, 14'h3}), 4);
        ld(1, 2'h2, 16'h1, 16'h1, 16'h0);
        walk(1, 2'h2, 2'h2, 84'({14'h1}), 1);
        @(posedge clk); #1;
        bitrev_mode = 1'h0;
        repeat (2) @(posedge clk);
        walk(0, 2'h2, 2'h2, 84'({14'h3}), 1);
    endtask
    task automatic t_exch;
        ld(1, 2'h0, 16'h123, 16'h0, 16'h0);
        walk(1, 2'h0, 2'h0, 84'({14'h123}), 1);
        pm(1'h0);
        pm(1'h1);
        @(posedge clk); #1;
        {data_bus_wr_data, ext_wr_en} = {16'hBEEF, 1'h1};
        @(posedge clk); #1;
        ext_wr_en = 1'h0;
        chk("ext read", 24'h0000EF, {8'h00, ext_rd_data});
        chk("pm write", 24'hBEEFEF, pgm_bus_wr_data);
    endtask
    task automatic summarize;
        $display("errors %0d compared %0d", n_errors, n_compared);
        if (n_errors == 0 && n_compared > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    initial begin
        repeat (5) @(posedge clk);
        #1 arst_n = 1'h1;
        t_circ;
        t_rev;
        t_exch;
        summarize;
    end
    initial begin
        #50000;
        n_errors++;
        summarize;
    end
endmodule
